// ==== pkg/pisc_pkg.sv ====
// pisc_pkg: constants, state type and register map of the input switch
package pisc_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NIN = 4;
  localparam int SEL_W = 2;

  // ---------------------------------------------------------------
  // states, gray along hold -> switch -> lock
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_SWITCH = 2'b01,
    ST_LOCK = 2'b11
  } pisc_st_e;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_PRIO = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_IRQ = 8'h0c;
  localparam logic [7:0] ADR_MASK = 8'h10;

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int CTL_AUTO = 0;
  localparam int CTL_REVERT = 1;
  localparam int CTL_HITLESS = 2;
  localparam int CTL_REGSEL = 3;
  localparam int CTL_SEL_LO = 4;
  localparam int CTRL_W = 6;
  localparam logic [5:0] CTRL_RST = 6'h06;
  localparam logic [7:0] PRIO_RST = 8'he4;

  // ---------------------------------------------------------------
  // status fields
  // ---------------------------------------------------------------
  localparam int STA_ACT_LO = 0;
  localparam int STA_HOLD = 2;
  localparam int STA_ALM_LO = 4;
  localparam int STA_SEL_LO = 8;

  // ---------------------------------------------------------------
  // interrupt bits
  // ---------------------------------------------------------------
  localparam int IRQ_SWITCH = 0;
  localparam int IRQ_HOLD_IN = 1;
  localparam int IRQ_HOLD_OUT = 2;
  localparam int IRQ_ALARM = 3;
  localparam int IRQ_W = 4;

  // ---------------------------------------------------------------
  // whole state of the top module
  // ---------------------------------------------------------------
  typedef struct packed {
    pisc_st_e st;
    logic [1:0] active;
    logic [1:0] tgt;
    logic [1:0] sel;
    logic [5:0] ctrl;
    logic [7:0] prio;
    logic [3:0] irq;
    logic [3:0] mask;
    logic pbo;
    logic ack;
    logic [31:0] rdat;
  } pisc_regs_s;

  localparam pisc_regs_s REGS_RST = '{
    st: ST_HOLD,
    active: 2'h0,
    tgt: 2'h0,
    sel: 2'h0,
    ctrl: CTRL_RST,
    prio: PRIO_RST,
    irq: 4'h0,
    mask: 4'h0,
    pbo: 1'b0,
    ack: 1'b0,
    rdat: 32'h0
  };

endpackage

// ==== verilog/pisc_prio.sv ====
// pisc_prio: picks the highest priority alarm-free input
`timescale 1ns/1ps
module pisc_prio (
  input wire logic [7:0] order,
  input wire logic [3:0] alarm,
  output logic [1:0] best,
  output logic found,
  output logic [1:0] top_idx,
  output logic top_ok
);

  logic [3:0] slot_ok;

  // ---------------------------------------------------------------
  // per slot validity
  // ---------------------------------------------------------------
  for (genvar i = 0; i < pisc_pkg::NIN; i++) begin : g_slot
    assign slot_ok[i] = !alarm[order[2*i +: 2]];
  end

  assign top_idx = order[1:0];
  assign top_ok = slot_ok[0];
  assign found = |slot_ok;

  // lowest slot number wins, so scan from the back
  always_comb begin
    best = order[1:0];
    for (int i = pisc_pkg::NIN - 1; i >= 0; i--) begin
      if (slot_ok[i]) begin
        best = order[2*i +: 2];
      end
    end
  end

endmodule

// ==== verilog/pisc_top.sv ====
// pisc_top: input clock selection, holdover and phase build-out control
//
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module pisc_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic input_select_bit0,
  input wire logic input_select_bit1,
  input wire logic [3:0] alarm_in,
  output logic [1:0] active_input,
  output logic holdover,
  output logic phase_buildout,
  output logic irq
);

  pisc_pkg::pisc_regs_s q;
  pisc_pkg::pisc_regs_s d;

  logic [1:0] best;
  logic found;
  logic [1:0] top_idx;
  logic top_ok;
  logic [1:0] man_idx;
  logic auto_m;
  logic revert_m;
  logic [3:0] ev;
  logic [3:0] clr;
  logic wr;
  logic want_ok;
  logic [1:0] want_idx;
  logic stay;

  // ---------------------------------------------------------------
  // priority selection
  // ---------------------------------------------------------------
  pisc_prio u_prio (
    .order(q.prio),
    .alarm(alarm_in),
    .best(best),
    .found(found),
    .top_idx(top_idx),
    .top_ok(top_ok)
  );

  assign auto_m = q.ctrl[pisc_pkg::CTL_AUTO];
  assign revert_m = q.ctrl[pisc_pkg::CTL_REVERT];

  // pins or register field
  // register path lets software override the pins
  assign man_idx = q.ctrl[pisc_pkg::CTL_REGSEL] ?
                   q.ctrl[pisc_pkg::CTL_SEL_LO +: 2] : q.sel;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    ev = '0;
    clr = '0;
    want_ok = 1'b0;
    want_idx = q.active;
    stay = 1'b0;
    d.pbo = 1'b0;
    d.sel = {input_select_bit1, input_select_bit0};

    // bus slave, one wait state, ack drops after one cycle
    d.ack = wb_cyc && wb_stb && !q.ack;
    wr = d.ack && wb_we;
    d.rdat = '0;
    if (d.ack && !wb_we) begin
      case (wb_adr)
        pisc_pkg::ADR_CTRL: d.rdat[5:0] = q.ctrl;
        pisc_pkg::ADR_PRIO: d.rdat[7:0] = q.prio;
        pisc_pkg::ADR_STAT: begin
          d.rdat[pisc_pkg::STA_ACT_LO +: 2] = q.active;
          d.rdat[pisc_pkg::STA_HOLD] = (q.st == pisc_pkg::ST_HOLD);
          d.rdat[pisc_pkg::STA_ALM_LO +: 4] = alarm_in;
          d.rdat[pisc_pkg::STA_SEL_LO +: 2] = q.sel;
        end
        pisc_pkg::ADR_IRQ: d.rdat[3:0] = q.irq;
        pisc_pkg::ADR_MASK: d.rdat[3:0] = q.mask;
        default: d.rdat = '0;
      endcase
    end
    if (wr && wb_sel[0]) begin
      case (wb_adr)
        pisc_pkg::ADR_CTRL: d.ctrl = wb_dat_w[5:0];
        pisc_pkg::ADR_PRIO: d.prio = wb_dat_w[7:0];
        pisc_pkg::ADR_IRQ: clr = wb_dat_w[3:0];
        pisc_pkg::ADR_MASK: d.mask = wb_dat_w[3:0];
        default: clr = '0;
      endcase
    end

    // input selection
    case (q.st)
      pisc_pkg::ST_HOLD, pisc_pkg::ST_LOCK: begin
        if (!auto_m) begin
          want_ok = !alarm_in[man_idx];
          want_idx = man_idx;
        end else if (q.st == pisc_pkg::ST_LOCK && !alarm_in[q.active] &&
                     !(revert_m && top_ok && q.active != top_idx)) begin
          stay = 1'b1;
          want_ok = 1'b1;
        end else if (revert_m && top_ok) begin
          want_ok = 1'b1;
          want_idx = top_idx;
        end else begin
          want_ok = found;
          want_idx = best;
        end
        if (!want_ok) begin
          d.st = pisc_pkg::ST_HOLD;
        end else if (stay) begin
          d.st = pisc_pkg::ST_LOCK;
        end else if (q.st == pisc_pkg::ST_HOLD || want_idx != q.active) begin
          d.st = pisc_pkg::ST_SWITCH;
          d.tgt = want_idx;
        end else begin
          d.st = pisc_pkg::ST_LOCK;
        end
        if (q.st == pisc_pkg::ST_LOCK && alarm_in[q.active]) begin
          ev[pisc_pkg::IRQ_ALARM] = 1'b1;
        end
      end
      pisc_pkg::ST_SWITCH: begin
        d.active = q.tgt;
        d.st = pisc_pkg::ST_LOCK;
        ev[pisc_pkg::IRQ_SWITCH] = 1'b1;
        // phase build-out on hitless change
        // equal input frequency is the host's affair, not checked here
        d.pbo = q.ctrl[pisc_pkg::CTL_HITLESS];
      end
      default: d.st = pisc_pkg::ST_HOLD;
    endcase

    if (q.st != pisc_pkg::ST_HOLD && d.st == pisc_pkg::ST_HOLD) begin
      ev[pisc_pkg::IRQ_HOLD_IN] = 1'b1;
    end
    if (q.st == pisc_pkg::ST_HOLD && d.st != pisc_pkg::ST_HOLD) begin
      ev[pisc_pkg::IRQ_HOLD_OUT] = 1'b1;
    end
    // set wins over a same-cycle clear
    d.irq = (q.irq & ~clr) | ev;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= pisc_pkg::REGS_RST;
    end else begin
      q <= d;
    end
  end

  assign wb_ack = q.ack;
  assign wb_dat_r = q.rdat;
  assign active_input = q.active;
  assign holdover = (q.st == pisc_pkg::ST_HOLD);
  assign phase_buildout = q.pbo;
  assign irq = |(q.irq & q.mask);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  ack_pulse_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wb_ack |=> !wb_ack
  ) else $error("ack held longer than one cycle");

  man_hold_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!auto_m && alarm_in[man_idx] && q.st != pisc_pkg::ST_SWITCH)
    |=> holdover
  ) else $error("manual pick of alarmed input not in holdover");

  // alarm on active starts a switch in auto mode if another input is clean
  auto_switch_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (auto_m && q.st == pisc_pkg::ST_LOCK && alarm_in[q.active] && found)
    |=> q.st == pisc_pkg::ST_SWITCH ##1 q.st == pisc_pkg::ST_LOCK
  ) else $error("alarm on active input did not switch");

  best_pick_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (auto_m && !revert_m && q.st == pisc_pkg::ST_LOCK &&
     alarm_in[q.active] && found)
    |=> ##1 active_input == $past(best, 2)
  ) else $error("switch did not take best priority input");

  auto_hold_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (auto_m && !found && q.st != pisc_pkg::ST_SWITCH) |=> holdover
  ) else $error("no valid input but not in holdover");

  revert_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (auto_m && revert_m && top_ok && q.st == pisc_pkg::ST_LOCK &&
     q.active != top_idx)
    |=> ##1 active_input == $past(top_idx, 2)
  ) else $error("auto-revert did not return to top input");

  no_early_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (auto_m && !revert_m && q.st == pisc_pkg::ST_LOCK &&
     !alarm_in[q.active])
    |=> q.st == pisc_pkg::ST_LOCK && $stable(active_input)
  ) else $error("switch before alarm declared");

  pbo_pulse_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (q.st == pisc_pkg::ST_SWITCH && q.ctrl[pisc_pkg::CTL_HITLESS])
    |=> phase_buildout ##1 !phase_buildout
  ) else $error("phase build-out pulse missing");

  sel_sync_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    1'b1 |=> q.sel == $past({input_select_bit1, input_select_bit0})
  ) else $error("select pins not registered");

  // read data only with ack
  rd_idle_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !wb_ack |-> wb_dat_r == 32'h0
  ) else $error("read data not zero while ack low");

  man_follow_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (!auto_m && !alarm_in[man_idx] && q.st == pisc_pkg::ST_LOCK &&
     q.active != man_idx)
    |=> q.st == pisc_pkg::ST_SWITCH ##1 active_input == $past(man_idx, 2)
  ) else $error("manual pick of clean input not taken");

  // clean manual pick leaves holdover
  // release edge still runs the reset branch, so sampled rst_n gates it
  hold_exit_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (rst_n && !auto_m && q.st == pisc_pkg::ST_HOLD && !alarm_in[man_idx])
    |=> q.st == pisc_pkg::ST_SWITCH
  ) else $error("holdover kept although manual pick is clean");

  alarm_flag_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (q.st == pisc_pkg::ST_LOCK && alarm_in[q.active])
    |=> q.irq[pisc_pkg::IRQ_ALARM]
  ) else $error("alarm on active input not flagged");

  switch_flag_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $changed(active_input) |-> q.irq[pisc_pkg::IRQ_SWITCH]
  ) else $error("input change not flagged");

  hold_in_flag_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(holdover) |-> q.irq[pisc_pkg::IRQ_HOLD_IN]
  ) else $error("holdover entry not flagged");

  hold_out_flag_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $fell(holdover) |-> q.irq[pisc_pkg::IRQ_HOLD_OUT]
  ) else $error("holdover exit not flagged");

  pbo_off_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !q.ctrl[pisc_pkg::CTL_HITLESS] |=> !phase_buildout
  ) else $error("build-out pulse with hitless off");

endmodule

// ==== tb/pisc_host_model.sv ====
// pisc_host_model: host driving the select pins and input alarms
`timescale 1ns/1ps
module pisc_host_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] want_sel,
  input wire logic [3:0] want_alarm,
  input wire logic force_sel,
  output logic input_select_bit0,
  output logic input_select_bit1,
  output logic [3:0] alarm_in
);
  logic [1:0] cur_q;
  assign input_select_bit0 = cur_q[0];
  assign input_select_bit1 = cur_q[1];
  // -------------------------------------------------------------
  // pins and alarms, launched on the rising edge
  // -------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= 2'h0;
      alarm_in <= 4'h0;
    end else begin
      alarm_in <= want_alarm;
      if (force_sel || !(alarm_in[cur_q] || alarm_in[want_sel])) begin
        cur_q <= want_sel;
      end
    end
  end
endmodule

// ==== tb/test_pisc_top.sv ====
// test_pisc_top: register and input switch sequences for pisc_top
`timescale 1ns/1ps
module test_pisc_top;
  logic mclk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, force_sel;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel, want_alarm, alarm_in;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  logic [1:0] want_sel, active_input;
  logic sel0, sel1, holdover, phase_buildout, irq;
  int err_total, tests_run, pbo_cnt, p0;

  pisc_top i_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .input_select_bit0(sel0), .input_select_bit1(sel1),
    .alarm_in(alarm_in), .active_input(active_input),
    .holdover(holdover), .phase_buildout(phase_buildout), .irq(irq));
  pisc_host_model i_host (.mclk(mclk), .rst_n(rst_n),
    .want_sel(want_sel), .want_alarm(want_alarm), .force_sel(force_sel),
    .input_select_bit0(sel0), .input_select_bit1(sel1),
    .alarm_in(alarm_in));

  // -------------------------------------------------------------
  // clock, pulse counter, watchdog
  // -------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (phase_buildout === 1'b1) begin
      pbo_cnt <= pbo_cnt + 1;
    end
  end
  // whole run is a few hundred cycles; 100 us is ample
  initial begin
    #100us;
    err_total++;
    end_sim();
  end

  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // classic cycle; entered and left on a rising edge
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    wb_sel <= s;
    @(posedge mclk);
    // no own limit: only the watchdog ends a hung cycle
    while (wb_ack !== 1'b1) begin
      @(posedge mclk);
    end
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic host(input logic [1:0] s, input logic [3:0] al,
                      input logic f);
    want_sel <= s;
    want_alarm <= al;
    force_sel <= f;
    @(posedge mclk);
  endtask
  // active input is only meaningful outside holdover
  task automatic wait_st(input logic [1:0] a, input logic h);
    int n;
    n = 0;
    while (!(holdover === h && (h || active_input === a)) && n < 30) begin
      @(posedge mclk);
      n++;
    end
    chk(32'({holdover, active_input}), 32'({h, h ? active_input : a}));
  endtask

  // -------------------------------------------------------------
  // sequences
  // -------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {wb_cyc, wb_stb, wb_we, force_sel} = 4'h0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0;
    want_sel = 2'h0;
    want_alarm = 4'h0;
    {err_total, tests_run, pbo_cnt} = {32'd0, 32'd0, 32'd0};
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    chk(rd, 32'h06);
    wb(1'b0, 8'h04, 32'h0, 4'hf);
    chk(rd, 32'he4);
    wb(1'b0, 8'h14, 32'h0, 4'hf);
    chk(rd, 32'h0);
    wait_st(2'h0, 1'b0);
    p0 = pbo_cnt;
    host(2'h1, 4'h0, 1'b0);
    wait_st(2'h1, 1'b0);
    @(posedge mclk);
    chk(pbo_cnt, p0 + 1);
    wb(1'b0, 8'h08, 32'h0, 4'hf);
    chk(rd, 32'h101);
    // hitless off: switch without build-out
    wb(1'b1, 8'h00, 32'h02, 4'hf);
    p0 = pbo_cnt;
    host(2'h2, 4'h0, 1'b0);
    wait_st(2'h2, 1'b0);
    @(posedge mclk);
    chk(pbo_cnt, p0);
    wb(1'b1, 8'h00, 32'h3e, 4'hf);
    wait_st(2'h3, 1'b0);
    wb(1'b1, 8'h00, 32'h06, 4'hf);
    wait_st(2'h2, 1'b0);
    host(2'h0, 4'h1, 1'b1);
    wait_st(2'h0, 1'b1);
    host(2'h1, 4'h1, 1'b1);
    wait_st(2'h1, 1'b0);
    host(2'h0, 4'h1, 1'b1);
    wait_st(2'h0, 1'b1);
    host(2'h0, 4'h0, 1'b0);
    wait_st(2'h0, 1'b0);
    // sticky events, mask, write-one clear
    wb(1'b1, 8'h10, 32'h2, 4'hf);
    chk(32'(irq), 32'h1);
    wb(1'b1, 8'h0c, 32'hf, 4'hf);
    chk(32'(irq), 32'h0);
    wb(1'b0, 8'h0c, 32'h0, 4'hf);
    chk(rd, 32'h0);
    wb(1'b1, 8'h10, 32'hf, 4'he);
    wb(1'b0, 8'h10, 32'h0, 4'hf);
    chk(rd, 32'h2);
    wb(1'b1, 8'h10, 32'h1, 4'hf);
    host(2'h1, 4'h0, 1'b0);
    wait_st(2'h1, 1'b0);
    @(posedge mclk);
    chk(32'(irq), 32'h1);
    wb(1'b1, 8'h0c, 32'h1, 4'hf);
    chk(32'(irq), 32'h0);
    // automatic mode with revert
    wb(1'b1, 8'h00, 32'h07, 4'hf);
    wait_st(2'h0, 1'b0);
    host(2'h1, 4'h3, 1'b0);
    wait_st(2'h2, 1'b0);
    host(2'h1, 4'h2, 1'b0);
    wait_st(2'h0, 1'b0);
    host(2'h1, 4'hf, 1'b0);
    wait_st(2'h0, 1'b1);
    wb(1'b0, 8'h08, 32'h0, 4'hf);
    chk(rd, 32'h1f4);
    host(2'h1, 4'hb, 1'b0);
    wait_st(2'h2, 1'b0);
    // without revert a clean top input is not taken
    wb(1'b1, 8'h00, 32'h05, 4'hf);
    host(2'h1, 4'h8, 1'b0);
    repeat (10) @(posedge mclk);
    chk(32'(active_input), 32'h2);
    host(2'h1, 4'hc, 1'b0);
    wait_st(2'h0, 1'b0);
    wb(1'b1, 8'h04, 32'h1b, 4'hf);
    wb(1'b1, 8'h00, 32'h07, 4'hf);
    host(2'h1, 4'h0, 1'b0);
    wait_st(2'h3, 1'b0);
    end_sim();
  end
endmodule
